/* logic/iob_pkg.sv */
// Constants, field positions and types of the internal oscillator block.
package iob_pkg;
   localparam int     SYS_CLK_HZ    = 125_000_000;
   localparam int     CLK_PERIOD_PS = 8000;
   localparam int     MF_FREQ_HZ    = 500_000;
   localparam int     LF_FREQ_HZ    = 31_000;
   localparam int     HF_MULT_LOG2  = 5;
   localparam longint PHASE_ONE     = 64'h0000_0001_0000_0000;
   localparam logic [31:0] MF_INC = 32'(longint'(MF_FREQ_HZ) * PHASE_ONE / SYS_CLK_HZ);
   localparam logic [31:0] LF_INC = 32'(longint'(LF_FREQ_HZ) * PHASE_ONE / SYS_CLK_HZ);
   localparam int     TRIM_STEP_LOG2 = 6;
   localparam logic [31:0] MF_STEP = MF_INC >> TRIM_STEP_LOG2;
   localparam int     PHASE_W   = 41;
   localparam int     PHASE_MSB = 31;
   // Times in their own units, then cycle counts rounded up.
   localparam int OSC_START_NS  = 2000;
   localparam int LF_START_NS   = 2000;
   localparam int PLL_START_US  = 2000;
   localparam int HF_LOCK_NS    = 1000;
   localparam int HF_STABLE_NS  = 4000;
   localparam int TRIM_STEP_NS  = 1000;
   localparam int OSC_START_CYC = (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LF_START_CYC  = (LF_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PLL_START_CYC = (PLL_START_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HF_LOCK_CYC   = (HF_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HF_STABLE_CYC = (HF_STABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TRIM_STEP_CYC = (TRIM_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W         = 18;
   localparam int SYNC_EDGES    = 2;
   // Register byte offsets.
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_TRIM  = 8'h04;
   localparam logic [7:0] REG_STATE = 8'h08;
   localparam logic [7:0] REG_CFG   = 8'h0c;
   // Control register fields and reset values, and the trim register reset value.
   localparam int CTRL_SRC_LSB  = 0;
   localparam int CTRL_FREQ_LSB = 3;
   localparam int CTRL_MULT     = 7;
   localparam logic [1:0] SRC_RST    = 2'h0;
   localparam logic [1:0] SRC_CFG    = 2'h0;
   localparam logic [1:0] SRC_TIMER  = 2'h1;
   localparam logic [3:0] FREQ_RST   = 4'h7;
   localparam logic [3:0] FREQ_LF    = 4'h0;
   localparam logic [3:0] FREQ_8M    = 4'he;
   localparam logic [4:0] TRIM_RST   = 5'h00;
   // Configuration word fields and reset values.
   localparam int CFG_OSC_LSB  = 0;
   localparam int CFG_MULT     = 3;
   localparam int CFG_CLKOUT_N = 4;
   localparam logic [2:0] CFG_OSC_RST  = 3'h4;
   localparam logic [2:0] CFG_INTERNAL = 3'h4;
   // Status register bit positions.
   localparam int STAT_LF     = 0;
   localparam int STAT_MF     = 1;
   localparam int STAT_HF     = 2;
   localparam int STAT_LOCK   = 3;
   localparam int STAT_STABLE = 4;
   localparam int STAT_MULT   = 5;
   localparam int STAT_BUSY   = 6;
   localparam int STAT_SRC    = 8;
   typedef enum logic [2:0] {
      SRC_LF = 3'b000, SRC_MF = 3'b001, SRC_HF = 3'b010,
      SRC_ML = 3'b011, SRC_EXT = 3'b100, SRC_TMR = 3'b101
   } iob_clk_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_START = 3'b001, ST_SYNC = 3'b010,
      ST_FALL = 3'b011, ST_HOLD = 3'b100
   } iob_state_e;
endpackage : iob_pkg

/* logic/iob_internal_osc.sv */
// Internal oscillator block: oscillator models, glitch-free selector and registers.
`timescale 1ns/1ps
module iob_internal_osc #(
   parameter int PLL_START_CYC = iob_pkg::PLL_START_CYC
) (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // Wishbone slave.
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatW,
   output logic      [31:0] wbDatR,
   output logic             wbAck,
   // Timer crystal clock and low clock demand from timers.
   input  wire logic        tmrClkIn,
   input  wire logic        lfNeeded,
   // Clock outputs.
   output logic             sysClk,
   output logic             lfClk,
   // Primary oscillator pin.
   input  wire logic        primaryPinIn,
   output logic             primaryPinOut,
   output logic             primaryPinOe,
   // Secondary oscillator pin.
   input  wire logic        secondaryPinIn,
   output logic             secondaryPinOut,
   output logic             secondaryPinOe,
   // Port logic side of both pins.
   input  wire logic        gpioPriOut,
   input  wire logic        gpioPriOe,
   input  wire logic        gpioSecOut,
   input  wire logic        gpioSecOe,
   output logic             gpioPriIn,
   output logic             gpioSecIn
);
   localparam int W   = iob_pkg::PHASE_W;
   localparam int LFI = 0;
   localparam int MFI = 1;
   localparam int HFI = 2;
   localparam int MLI = 3;

   logic [1:0]            srcSel;
   logic [3:0]            freqSel;
   logic                  softMult;
   logic [4:0]            trimReg;
   logic [2:0]            oscCfg;
   logic                  cfgMult;
   logic                  clkOutEnN;
   logic signed [4:0]     trimEff;
   logic [7:0]            driftCnt;
   logic [W-1:0]          acc [4];
   logic [31:0]           inc [4];
   logic [3:0]            oscOn;
   logic [3:0]            need;
   logic [3:0]            rdy;
   logic [iob_pkg::CNT_W-1:0] oscCnt [4];
   logic [iob_pkg::CNT_W-1:0] lim [4];
   logic [9:0]            hfSettle;
   logic                  hfLock;
   logic                  hfStable;
   logic [10:0]           statusReg;
   logic                  multOn;
   logic                  internalMode;
   logic signed [33:0]    mfIncS;
   iob_pkg::iob_state_e   state;
   iob_pkg::iob_clk_e     curSrc;
   iob_pkg::iob_clk_e     tgtSrc;
   iob_pkg::iob_clk_e     wantSrc;
   logic [3:0]            curShift;
   logic [3:0]            tgtShift;
   logic [3:0]            wantShift;
   logic                  syncCnt;
   logic                  prevCur;
   logic                  prevTgt;
   logic                  curLvl;
   logic                  tgtLvl;
   logic                  tgtRise;
   logic                  curFall;
   logic                  next_sysClk;
   logic                  regAcc;
   logic                  regWr;
   logic [6:0]            wantDec;

   // Frequency code to source and postscaler shift.
   function automatic logic [6:0] freqDecode(input logic [3:0] code, input logic mult);
      logic [6:0] r;
      r = {iob_pkg::SRC_MF, 4'h0};
      case (code)
         4'h0: r = {iob_pkg::SRC_LF, 4'h0};
         4'h1: r = {iob_pkg::SRC_MF, 4'h4};
         4'h2: r = {iob_pkg::SRC_MF, 4'h3};
         4'h3: r = {iob_pkg::SRC_MF, 4'h2};
         4'h4: r = {iob_pkg::SRC_MF, 4'h1};
         4'h5: r = {iob_pkg::SRC_HF, 4'h8};
         4'h6: r = {iob_pkg::SRC_HF, 4'h7};
         4'h7: r = {iob_pkg::SRC_MF, 4'h0};
         4'h8: r = {iob_pkg::SRC_HF, 4'h9};
         4'h9: r = {iob_pkg::SRC_HF, 4'h6};
         4'ha: r = {iob_pkg::SRC_HF, 4'h5};
         4'hb: r = {iob_pkg::SRC_HF, 4'h4};
         4'hc: r = {iob_pkg::SRC_HF, 4'h3};
         4'hd: r = {iob_pkg::SRC_HF, 4'h2};
         4'he: r = mult ? {iob_pkg::SRC_ML, 4'h0} : {iob_pkg::SRC_HF, 4'h1};
         4'hf: r = {iob_pkg::SRC_HF, 4'h0};
         default: r = {iob_pkg::SRC_MF, 4'h0};
      endcase
      return r;
   endfunction : freqDecode

   // Level of a selected clock; external sources arrive on pins.
   function automatic logic clkLevel(input iob_pkg::iob_clk_e s, input logic [3:0] sh);
      logic r;
      r = 1'b0;
      case (s)
         iob_pkg::SRC_EXT: r = primaryPinIn;
         iob_pkg::SRC_TMR: r = tmrClkIn;
         default:          r = acc[s[1:0]][iob_pkg::PHASE_MSB + int'(sh)];
      endcase
      return r;
   endfunction : clkLevel

   // Whether the switch logic currently depends on an internal source.
   function automatic logic uses(input iob_pkg::iob_clk_e s);
      return (curSrc == s) || (state != iob_pkg::ST_IDLE && tgtSrc == s);
   endfunction : uses

   function automatic logic srcReady(input iob_pkg::iob_clk_e s);
      return (s == iob_pkg::SRC_EXT || s == iob_pkg::SRC_TMR) ? 1'b1 : rdy[s[1:0]];
   endfunction : srcReady

   assign multOn = cfgMult | softMult;
   assign internalMode = srcSel[1] ||
                         (srcSel == iob_pkg::SRC_CFG && oscCfg == iob_pkg::CFG_INTERNAL);

   // The decoded word is split here so the enum only ever takes a cast value.
   always_comb begin
      wantDec = {iob_pkg::SRC_EXT, 4'h0};
      if (internalMode) begin
         wantDec = freqDecode(freqSel, multOn);
      end else if (srcSel == iob_pkg::SRC_TIMER) begin
         wantDec = {iob_pkg::SRC_TMR, 4'h0};
      end
      wantSrc   = iob_pkg::iob_clk_e'(wantDec[6:4]);
      wantShift = wantDec[3:0];
   end

   // The multiplier hangs off the high source, which hangs off the medium one.
   always_comb begin
      need[MLI] = uses(iob_pkg::SRC_ML) || cfgMult;
      need[HFI] = uses(iob_pkg::SRC_HF) || need[MLI];
      need[MFI] = uses(iob_pkg::SRC_MF) || need[HFI];
      need[LFI] = uses(iob_pkg::SRC_LF) || lfNeeded;
   end

   assign mfIncS = $signed({2'b00, iob_pkg::MF_INC}) +
                   $signed(trimEff) * $signed({2'b00, iob_pkg::MF_STEP});
   assign inc[LFI] = iob_pkg::LF_INC;
   assign inc[MFI] = mfIncS[31:0];
   assign inc[HFI] = mfIncS[31:0] << iob_pkg::HF_MULT_LOG2;
   assign inc[MLI] = mfIncS[31:0] << (iob_pkg::HF_MULT_LOG2 + 1);
   assign lim[LFI] = iob_pkg::CNT_W'(iob_pkg::LF_START_CYC);
   assign lim[MFI] = iob_pkg::CNT_W'(iob_pkg::OSC_START_CYC);
   assign lim[HFI] = iob_pkg::CNT_W'(iob_pkg::OSC_START_CYC);
   assign lim[MLI] = iob_pkg::CNT_W'(PLL_START_CYC);

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         rdy[i] = oscOn[i] && (oscCnt[i] == lim[i]);
      end
   end

   // Oscillator enables, start-up counters and phase accumulators.
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (!rstn) begin
            oscOn[i]  <= 1'b0;
            oscCnt[i] <= '0;
            acc[i]    <= '0;
         end else begin
            oscOn[i] <= need[i] && (i == LFI || i == MFI || rdy[(i > 0) ? i - 1 : 0]);
            if (!oscOn[i]) begin
               oscCnt[i] <= '0;
            end else if (oscCnt[i] != lim[i]) begin
               oscCnt[i] <= oscCnt[i] + 1'b1;
            end
            if (oscOn[i]) begin
               acc[i] <= acc[i] + {{(W-32){1'b0}}, inc[i]};
            end
         end
      end
   end

   // Settling after the high source is ready gives the locked and stable flags.
   always_ff @(posedge sys_clk) begin
      if (!rstn || !rdy[HFI]) begin
         hfSettle <= '0;
      end else if (hfSettle != 10'(iob_pkg::HF_STABLE_CYC)) begin
         hfSettle <= hfSettle + 1'b1;
      end
   end
   assign hfLock   = rdy[HFI] && hfSettle >= 10'(iob_pkg::HF_LOCK_CYC);
   assign hfStable = rdy[HFI] && hfSettle == 10'(iob_pkg::HF_STABLE_CYC);

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         statusReg <= '0;
      end else begin
         statusReg[iob_pkg::STAT_LF]     <= rdy[LFI];
         statusReg[iob_pkg::STAT_MF]     <= rdy[MFI];
         statusReg[iob_pkg::STAT_HF]     <= rdy[HFI];
         statusReg[iob_pkg::STAT_LOCK]   <= hfLock;
         statusReg[iob_pkg::STAT_STABLE] <= hfStable;
         statusReg[iob_pkg::STAT_MULT]   <= rdy[MLI];
         statusReg[iob_pkg::STAT_BUSY]   <= state != iob_pkg::ST_IDLE;
         statusReg[7]                    <= 1'b0;
         statusReg[iob_pkg::STAT_SRC +: 3] <= curSrc;
      end
   end

   // The applied trim walks one step at a time toward the written value.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         trimEff  <= '0;
         driftCnt <= '0;
      end else begin
         driftCnt <= (driftCnt == 8'(iob_pkg::TRIM_STEP_CYC - 1)) ? 8'h00 : driftCnt + 1'b1;
         if (driftCnt == 8'h00 && trimEff != $signed(trimReg)) begin
            trimEff <= (trimEff < $signed(trimReg)) ? trimEff + 5'sd1 : trimEff - 5'sd1;
         end
      end
   end

   // The level function reads the accumulators and pins directly, so it must sit in a
   // process that follows those reads; a continuous assignment would only see its arguments.
   always_comb begin
      curLvl = clkLevel(curSrc, curShift);
      tgtLvl = clkLevel(tgtSrc, tgtShift);
   end
   assign tgtRise = tgtLvl && !prevTgt;
   assign curFall = !curLvl && prevCur;

   // Switch sequence; a source that stops mid-switch leaves it waiting.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state    <= iob_pkg::ST_IDLE;
         curSrc   <= iob_pkg::SRC_EXT;
         curShift <= 4'h0;
         tgtSrc   <= iob_pkg::SRC_EXT;
         tgtShift <= 4'h0;
         syncCnt  <= 1'b0;
      end else begin
         case (state)
            iob_pkg::ST_IDLE: begin
               if (wantSrc != curSrc || wantShift != curShift) begin
                  tgtSrc   <= wantSrc;
                  tgtShift <= wantShift;
                  syncCnt  <= 1'b0;
                  if (wantSrc == curSrc || wantSrc == iob_pkg::SRC_EXT ||
                      wantSrc == iob_pkg::SRC_TMR) begin
                     state <= iob_pkg::ST_FALL;
                  end else if (srcReady(wantSrc)) begin
                     state <= iob_pkg::ST_SYNC;
                  end else begin
                     state <= iob_pkg::ST_START;
                  end
               end
            end
            iob_pkg::ST_START: begin
               if (srcReady(tgtSrc)) begin
                  state <= iob_pkg::ST_SYNC;
               end
            end
            iob_pkg::ST_SYNC: begin
               if (tgtRise) begin
                  syncCnt <= 1'b1;
                  if (syncCnt) begin
                     state <= iob_pkg::ST_FALL;
                  end
               end
            end
            iob_pkg::ST_FALL: begin
               if (curFall) begin
                  state <= iob_pkg::ST_HOLD;
               end
            end
            iob_pkg::ST_HOLD: begin
               if (tgtRise) begin
                  curSrc   <= tgtSrc;
                  curShift <= tgtShift;
                  state    <= iob_pkg::ST_IDLE;
               end
            end
            default: state <= iob_pkg::ST_IDLE;
         endcase
      end
   end

   always_comb begin
      if (state == iob_pkg::ST_HOLD) begin
         next_sysClk = tgtRise;
      end else begin
         next_sysClk = curLvl;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         prevCur <= 1'b0;
         prevTgt <= 1'b0;
         sysClk  <= 1'b0;
         lfClk   <= 1'b0;
      end else begin
         prevCur <= curLvl;
         prevTgt <= tgtLvl;
         sysClk  <= next_sysClk;
         lfClk   <= rdy[LFI] && acc[LFI][iob_pkg::PHASE_MSB];
      end
   end

   // Pins.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         primaryPinOut   <= 1'b0;
         primaryPinOe    <= 1'b0;
         secondaryPinOut <= 1'b0;
         secondaryPinOe  <= 1'b0;
         gpioPriIn       <= 1'b0;
         gpioSecIn       <= 1'b0;
      end else begin
         primaryPinOut   <= gpioPriOut;
         primaryPinOe    <= internalMode && gpioPriOe;
         secondaryPinOut <= clkOutEnN ? gpioSecOut : next_sysClk;
         secondaryPinOe  <= clkOutEnN ? gpioSecOe : 1'b1;
         gpioPriIn       <= primaryPinIn;
         gpioSecIn       <= secondaryPinIn;
      end
   end

   // Wishbone slave: one wait state, unmapped reads return zero.
   assign regAcc = wbCyc && wbStb && !wbAck;
   assign regWr  = regAcc && wbWe && wbSel[0];

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         srcSel    <= iob_pkg::SRC_RST;
         freqSel   <= iob_pkg::FREQ_RST;
         softMult  <= 1'b0;
         trimReg   <= iob_pkg::TRIM_RST;
         oscCfg    <= iob_pkg::CFG_OSC_RST;
         cfgMult   <= 1'b0;
         clkOutEnN <= 1'b1;
      end else if (regWr) begin
         case ({wbAdr[7:2], 2'b00})
            iob_pkg::REG_CTRL: begin
               srcSel   <= wbDatW[iob_pkg::CTRL_SRC_LSB +: 2];
               freqSel  <= wbDatW[iob_pkg::CTRL_FREQ_LSB +: 4];
               softMult <= wbDatW[iob_pkg::CTRL_MULT];
            end
            iob_pkg::REG_TRIM: trimReg <= wbDatW[4:0];
            iob_pkg::REG_CFG: begin
               oscCfg    <= wbDatW[iob_pkg::CFG_OSC_LSB +: 3];
               cfgMult   <= wbDatW[iob_pkg::CFG_MULT];
               clkOutEnN <= wbDatW[iob_pkg::CFG_CLKOUT_N];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         wbAck  <= 1'b0;
         wbDatR <= '0;
      end else begin
         wbAck  <= regAcc;
         wbDatR <= '0;
         if (regAcc && !wbWe) begin
            case ({wbAdr[7:2], 2'b00})
               iob_pkg::REG_CTRL:  wbDatR <= {24'h000000, softMult, freqSel, 1'b0, srcSel};
               iob_pkg::REG_TRIM:  wbDatR <= {27'h0000000, trimReg};
               iob_pkg::REG_STATE: wbDatR <= {21'h000000, statusReg};
               iob_pkg::REG_CFG:   wbDatR <= {27'h0000000, clkOutEnN, cfgMult, oscCfg};
               default:            wbDatR <= '0;
            endcase
         end
      end
   end

   localparam int LF_START = iob_pkg::LF_START_CYC;

   a_reset_fields: assert property (@(posedge sys_clk) !rstn |=>
      freqSel == iob_pkg::FREQ_RST && srcSel == iob_pkg::SRC_RST && trimReg == 5'h00)
      else $error("reset values of select fields wrong");
   a_hold_low: assert property (@(posedge sys_clk) disable iff (!rstn)
      state == iob_pkg::ST_HOLD && !tgtRise |=> !sysClk)
      else $error("system clock not held low in hold");
   a_hf_from_mf: assert property (@(posedge sys_clk) disable iff (!rstn)
      rdy[HFI] |-> rdy[MFI] && oscOn[MFI])
      else $error("high source runs without medium oscillator");
   a_lock_order: assert property (@(posedge sys_clk) disable iff (!rstn)
      statusReg[iob_pkg::STAT_STABLE] |-> statusReg[iob_pkg::STAT_LOCK] &&
      statusReg[iob_pkg::STAT_HF])
      else $error("stable flag without locked and ready");
   a_lf_start: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(rdy[LFI]) |-> $past(oscCnt[LFI]) == 18'(LF_START - 1))
      else $error("low oscillator ready before start-up");
   a_same_src: assert property (@(posedge sys_clk) disable iff (!rstn)
      state == iob_pkg::ST_IDLE && wantSrc == curSrc && wantShift != curShift
      |=> state == iob_pkg::ST_FALL)
      else $error("same source switch took a start-up");
   a_pin_gpio: assert property (@(posedge sys_clk) disable iff (!rstn)
      internalMode |=> primaryPinOe == $past(gpioPriOe))
      else $error("primary pin not port logic in internal mode");
   a_trim_drift: assert property (@(posedge sys_clk) disable iff (!rstn)
      trimEff != $past(trimEff) |-> trimEff - $past(trimEff) == 5'sd1 ||
      $past(trimEff) - trimEff == 5'sd1)
      else $error("trim jumped more than one step");
   a_mult_forced: assert property (@(posedge sys_clk) disable iff (!rstn)
      cfgMult && !softMult |-> need[MLI] && multOn)
      else $error("configured multiplier not active");
   a_lf_select: assert property (@(posedge sys_clk) disable iff (!rstn)
      srcSel[1] && freqSel == iob_pkg::FREQ_LF |-> wantSrc == iob_pkg::SRC_LF)
      else $error("code zero does not pick low oscillator");
   c_to_hf: cover property (@(posedge sys_clk) disable iff (!rstn)
      state == iob_pkg::ST_HOLD ##1 curSrc == iob_pkg::SRC_HF);
   c_to_lf: cover property (@(posedge sys_clk) disable iff (!rstn)
      state == iob_pkg::ST_HOLD ##1 curSrc == iob_pkg::SRC_LF);
   c_stable: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(hfStable));
endmodule : iob_internal_osc

/* testbench/internal_oscillator_block_tb_top.sv */
// Self-checking bench for the internal oscillator block.
`timescale 1ns/1ps
module internal_oscillator_block_tb_top;
   logic        sys_clk, rstn, wbCyc, wbStb, wbWe, wbAck, sysClk, lfClk;
   logic [7:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatW, wbDatR, rd;
   logic        tmrClkIn, lfNeeded, primaryPinIn, primaryPinOut, primaryPinOe;
   logic        secondaryPinIn, secondaryPinOut, secondaryPinOe, gpioPriIn, gpioSecIn;
   logic        gpioPriOut, gpioPriOe, gpioSecOut, gpioSecOe, prevOut, prevOe, prevIn;
   logic        prevSOut, prevSOe, prevSIn;
   int          errors, samples_checked;
   int          nSys, nLf;
   int          mdl [4];
   iob_internal_osc #(.PLL_START_CYC(20)) u_iob_internal_osc (.sys_clk(sys_clk), .rstn(rstn),
      .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .tmrClkIn(tmrClkIn),
      .lfNeeded(lfNeeded), .sysClk(sysClk), .lfClk(lfClk), .primaryPinIn(primaryPinIn),
      .primaryPinOut(primaryPinOut), .primaryPinOe(primaryPinOe),
      .secondaryPinIn(secondaryPinIn), .secondaryPinOut(secondaryPinOut),
      .secondaryPinOe(secondaryPinOe), .gpioPriOut(gpioPriOut), .gpioPriOe(gpioPriOe),
      .gpioSecOut(gpioSecOut), .gpioSecOe(gpioSecOe), .gpioPriIn(gpioPriIn),
      .gpioSecIn(gpioSecIn));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Pin and timer inputs toggle randomly so the pass-through paths see traffic.
   always @(posedge sys_clk) begin
      {tmrClkIn, lfNeeded, primaryPinIn, secondaryPinIn} <= 4'($urandom);
      {gpioPriOut, gpioPriOe, gpioSecOut, gpioSecOe} <= 4'($urandom);
      {prevOut, prevOe, prevIn} <= {gpioPriOut, gpioPriOe, primaryPinIn};
      {prevSOut, prevSOe, prevSIn} <= {gpioSecOut, gpioSecOe, secondaryPinIn};
   end
   task automatic final_report;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge sys_clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} <= {2'h3, we, adr, dat, sel};
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      rd = wbDatR;
      {wbCyc, wbStb} <= 2'h0;
      if (n >= 50) chk(32'hdead, 32'h0);
      if (we && sel[0] && adr < 8'h10 && adr != 8'h08)
         mdl[adr[3:2]] = dat & ((adr[3:2] == 2'h0) ? 32'hfb : 32'h1f);
      if (!we && adr != 8'h08) chk(rd, (adr < 8'h10) ? 32'(mdl[adr[3:2]]) : 32'h0);
   endtask : acc
   task automatic wait_src(input logic [2:0] src);
      for (int i = 0; i < 6000 && (i == 0 || rd[10:8] !== src); i++)
         acc(1'b0, 8'h08, 32'h0, 4'hf);
      chk(32'(rd[10:8]), 32'(src));
   endtask : wait_src
   // Counts rising edges of both clock outputs over a window, sampled mid-cycle.
   task automatic count_rises(input int cyc, output int ns, output int nl);
      logic ps, pl;
      ns = 0;
      nl = 0;
      @(negedge sys_clk);
      {ps, pl} = {sysClk, lfClk};
      repeat (cyc) begin
         @(negedge sys_clk);
         ns += int'(sysClk && !ps);
         nl += int'(lfClk && !pl);
         {ps, pl} = {sysClk, lfClk};
      end
   endtask : count_rises
   task automatic do_reset(input int n);
      rstn <= 1'b0;
      repeat (n) @(posedge sys_clk);
      rstn <= 1'b1;
      mdl = '{32'h38, 32'h0, 32'h0, 32'h14};
   endtask : do_reset
   initial begin
      {rstn, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW, rd} = '0;
      {tmrClkIn, lfNeeded, primaryPinIn, secondaryPinIn} = '0;
      {gpioPriOut, gpioPriOe, gpioSecOut, gpioSecOe} = '0;
      void'($urandom(32'h868347e1));
      do_reset(5);
      foreach (mdl[i]) acc(1'b0, 8'(i * 4), 32'h0, 4'hf);
      acc(1'b0, 8'h10, 32'h0, 4'hf);
      wait_src(3'h1);
      chk(32'(rd[1]), 32'h1);
      acc(1'b1, 8'h04, $urandom, 4'hf);
      acc(1'b1, 8'h04, $urandom, 4'he);
      acc(1'b0, 8'h04, 32'h0, 4'hf);
      repeat (20) begin
         @(negedge sys_clk);
         chk({primaryPinOut, primaryPinOe, gpioPriIn}, {prevOut, prevOe, prevIn});
         chk({secondaryPinOut, secondaryPinOe, gpioSecIn}, {prevSOut, prevSOe, prevSIn});
      end
      acc(1'b1, 8'h00, 32'h7a, 4'h1);
      wait_src(3'h2);
      chk(32'(rd[2]), 32'h1);
      // 16 MHz over 8 us is 128 rises; the trim may move it by up to a quarter.
      count_rises(1000, nSys, nLf);
      chk(32'(nSys >= 95 && nSys <= 161), 32'h1);
      acc(1'b0, 8'h08, 32'h0, 4'hf);
      chk(32'(rd[4:3]), 32'h3);
      acc(1'b1, 8'h0c, 32'h04, 4'h1);
      repeat (20) begin
         @(negedge sys_clk);
         chk({secondaryPinOut, secondaryPinOe}, {sysClk, 1'b1});
      end
      acc(1'b0, 8'h0c, 32'h0, 4'hf);
      acc(1'b1, 8'h00, 32'h6a, 4'h1);
      for (int i = 0; i < 40 && (i == 0 || rd[6] !== 1'b0); i++) acc(1'b0, 8'h08, 0, 4'hf);
      chk(32'({rd[6], rd[10:8]}), 32'h2);
      acc(1'b1, 8'h00, 32'hf2, 4'h1);
      wait_src(3'h3);
      count_rises(1000, nSys, nLf);
      chk(32'(nSys >= 190 && nSys <= 318), 32'h1);
      acc(1'b1, 8'h00, 32'h02, 4'h1);
      wait_src(3'h0);
      chk(32'(rd[0]), 32'h1);
      // One 31 kHz period is about 4032 cycles, so this window holds one or two rises.
      count_rises(4100, nSys, nLf);
      chk(32'(nSys >= 1 && nSys <= 2), 32'h1);
      chk(32'(nLf >= 1 && nLf <= 2), 32'h1);
      do_reset(2);
      acc(1'b0, 8'h00, 32'h0, 4'hf);
      acc(1'b0, 8'h0c, 32'h0, 4'hf);
      final_report();
   end
   initial begin
      #400000;
      errors++;
      final_report();
   end
endmodule : internal_oscillator_block_tb_top
